// *** rtl/cic_polyphase_decimator.sv ***
// Purpose: CIC decimate-by-10, polyphase decimate-by-2.5, final FIR.
// Assumes: chain_mode is static; taps are unity weighted.
// Notes: Final FIR runs inline (single) or in parallel (chained).
`timescale 1ns/100ps
`include "decim_consts.svh"

// Summary of operation
// - Fifth-order CIC keeps one output per ten input samples.
// - Step zero waits until five new CIC samples sit in RAM.
// - Single arrangement runs a 12-tap then a 13-tap phase.
// - The 12-tap phase reads with a three-sample pointer offset.
// - Both phases give two evenly spaced outputs per five inputs.
// - Single arrangement passes each phase output to a 28-tap FIR.
// - Last step branches back to the wait step.
// - All work for two outputs fits within 50 compute clocks.
// - Each RAM write takes one clock in the single arrangement; wait and loop take two.
// - Outputs are 24-bit in-phase and quadrature results.
// - Single arrangement uses one channel engine per receiver.
// - Chained arrangement runs wait, 34-tap, 33-tap, loop.
// - The 34-tap phase reads with a two-sample pointer offset.
// - Chained phase outputs feed a separate 44-tap FIR engine.
// - Chained FIR engine spends 22 clocks per 44-tap run.
// - Spare clocks may hold extra taps at two per clock.
module cic_polyphase_decimator
    import decim_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic chain_mode,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic signed [15:0] in_i,
    input wire logic signed [15:0] in_q,
    output logic out_valid,
    input wire logic out_ready,
    output logic [23:0] out_i,
    output logic [23:0] out_q
);

    // Input handshake and decimation counter
    logic in_ready_q;
    logic [3:0] dec_cnt_q;
    wire take = in_valid & in_ready_q;
    wire dec_hit = take & (dec_cnt_q == `CIC_LAST);
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dec_cnt_q <= 4'h0;
        end else if (take) begin
            dec_cnt_q <= dec_hit ? 4'h0 : dec_cnt_q + 4'h1;
        end
    end

    // CIC per lane: integrators at input rate, combs at one in ten
    cic_t integ_q [2][`CIC_STAGES];
    cic_t dly_q [2][`CIC_STAGES];
    cic_t cmb [2][`CIC_STAGES+1];
    sample_t cic_s_q [2];
    logic cic_v_q;
    wire cic_t lane_in [2] = '{cic_t'(in_i), cic_t'(in_q)};
    for (genvar l = 0; l < 2; l++) begin : g_lane
        assign cmb[l][0] = integ_q[l][`CIC_STAGES-1];
        for (genvar j = 0; j < `CIC_STAGES; j++) begin : g_stage
            wire cic_t src = (j == 0) ? lane_in[l] : integ_q[l][(j == 0) ? 0 : j-1];
            assign cmb[l][j+1] = cmb[l][j] - dly_q[l][j];
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    integ_q[l][j] <= '0;
                    dly_q[l][j] <= '0;
                end else begin
                    if (take) integ_q[l][j] <= integ_q[l][j] + src;
                    if (dec_hit) dly_q[l][j] <= cmb[l][j];
                end
            end
        end
        wire cic_t scaled = cmb[l][`CIC_STAGES] >>> `CIC_SHIFT;
        always_ff @(posedge sys_clk) begin
            if (rst) cic_s_q[l] <= '0;
            else if (dec_hit) cic_s_q[l] <= scaled[23:0];
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) cic_v_q <= 1'b0;
        else cic_v_q <= dec_hit;
    end

    // Arrangement selection
    wire [5:0] taps_a = chain_mode ? `CC_TAPS_A : `SC_TAPS_A;
    wire [5:0] taps_b = chain_mode ? `CC_TAPS_B : `SC_TAPS_B;
    wire [5:0] offs_a = chain_mode ? `CC_OFFS_A : `SC_OFFS_A;
    wire [5:0] taps_f = chain_mode ? `CC_TAPS_F : `SC_TAPS_F;

    // Engine state
    eng_state_e st_q, st_d;
    ptr_t wr_ptr_q, k_q, fptr_q, fk_q, base_q;
    logic [5:0] new_cnt_q;
    logic second_q, fin_run_q, res_v_q;
    acc_t acc_q [2];
    acc_t facc_q [2];
    sample_t pp_q [2];
    sample_t res_q [2];
    sample_t ram_q [2][64];
    sample_t fram_q [2][64];

    // Phase read addresses and tap sums, two taps per clock
    wire in_a = (st_q == S_PH_A);
    wire [5:0] cur_taps = in_a ? taps_a : taps_b;
    wire ptr_t rd0 = ptr_t'(base_q - 6'h01 - (in_a ? offs_a : 6'h00) - k_q);
    wire ptr_t rd1 = ptr_t'(rd0 - 6'h01);
    wire has1 = (7'(k_q) + 7'h01) < 7'(cur_taps);
    wire ph_last = (7'(k_q) + 7'h02) >= 7'(cur_taps);
    wire release_ok = (st_q == S_WAIT) && (new_cnt_q >= `WAIT_COUNT);
    wire fin_busy = fin_run_q | res_v_q;
    wire fwr_go = (st_q == S_FWR) && !fin_busy;
    acc_t psum [2];
    acc_t pnext [2];
    acc_t pshift [2];
    for (genvar l = 0; l < 2; l++) begin : g_psum
        assign psum[l] = acc_t'(ram_q[l][rd0]) + (has1 ? acc_t'(ram_q[l][rd1]) : '0);
        assign pnext[l] = acc_q[l] + psum[l];
        assign pshift[l] = pnext[l] >>> `PP_SHIFT;
    end

    // Final FIR engine read path
    wire ptr_t frd0 = ptr_t'(fptr_q - 6'h01 - fk_q);
    wire ptr_t frd1 = ptr_t'(frd0 - 6'h01);
    wire fhas1 = (7'(fk_q) + 7'h01) < 7'(taps_f);
    wire f_last = (7'(fk_q) + 7'h02) >= 7'(taps_f);
    acc_t fnext [2];
    acc_t fshift [2];
    for (genvar l = 0; l < 2; l++) begin : g_fsum
        assign fnext[l] = facc_q[l] + acc_t'(fram_q[l][frd0])
                        + (fhas1 ? acc_t'(fram_q[l][frd1]) : '0);
        assign fshift[l] = fnext[l] >>> `FIN_SHIFT;
    end

    // Program sequencer
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            S_WAIT: if (release_ok) st_d = S_PH_A;
            S_PH_A, S_PH_B: if (ph_last) st_d = S_FWR;
            S_FWR: begin
                if (fwr_go) begin
                    if (!chain_mode) st_d = S_FRUN;
                    else st_d = second_q ? S_LOOP : S_PH_B;
                end
            end
            S_FRUN: if (!fin_busy) st_d = second_q ? S_LOOP : S_PH_B;
            S_LOOP: st_d = S_WAIT;
            default: st_d = S_WAIT;
        endcase
    end

    // New-sample count: writes add, release removes five
    wire [5:0] cnt_add = new_cnt_q + {5'h00, cic_v_q};
    wire [5:0] new_cnt_d = release_ok ? 6'(cnt_add - `WAIT_COUNT) : cnt_add;

    // Sample RAM writes and counters
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr_ptr_q <= '0;
            base_q <= '0;
            new_cnt_q <= '0;
            in_ready_q <= 1'b0;
        end else begin
            if (cic_v_q) wr_ptr_q <= wr_ptr_q + 6'h01;
            // Read base only moves by the released five, later writes wait
            if (release_ok) base_q <= base_q + `WAIT_COUNT;
            new_cnt_q <= new_cnt_d;
            in_ready_q <= new_cnt_d < `PEND_LIMIT;
        end
    end
    always_ff @(posedge sys_clk) begin
        for (int l = 0; l < 2; l++) begin
            if (cic_v_q) ram_q[l][wr_ptr_q] <= cic_s_q[l];
            if (fwr_go) fram_q[l][fptr_q] <= pp_q[l];
        end
    end

    // Polyphase datapath
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_q <= S_WAIT;
            k_q <= '0;
            second_q <= 1'b0;
            acc_q <= '{default: '0};
            pp_q <= '{default: '0};
        end else begin
            st_q <= st_d;
            if (st_q == S_PH_A || st_q == S_PH_B) begin
                k_q <= ph_last ? 6'h00 : k_q + 6'h02;
                if (ph_last) acc_q <= '{default: '0};
                else acc_q <= pnext;
                if (ph_last) pp_q <= '{pshift[0][23:0], pshift[1][23:0]};
            end
            if (st_q == S_PH_B && ph_last) second_q <= 1'b1;
            if (st_q == S_LOOP) second_q <= 1'b0;
        end
    end

    // Buffer occupancy, read by the final engine's hand-off
    logic v0_q, v1_q;
    wire push = res_v_q & ~v1_q;
    wire out_stall = res_v_q & v1_q;

    // Final FIR engine, one clock per two taps
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fptr_q <= '0;
            fk_q <= '0;
            fin_run_q <= 1'b0;
            res_v_q <= 1'b0;
            facc_q <= '{default: '0};
            res_q <= '{default: '0};
        end else begin
            if (fwr_go) begin
                fptr_q <= fptr_q + 6'h01;
                fin_run_q <= 1'b1;
            end
            if (fin_run_q) begin
                fk_q <= f_last ? 6'h00 : fk_q + 6'h02;
                if (f_last) facc_q <= '{default: '0};
                else facc_q <= fnext;
                if (f_last) begin
                    fin_run_q <= 1'b0;
                    res_v_q <= 1'b1;
                    res_q <= '{fshift[0][23:0], fshift[1][23:0]};
                end
            end
            if (push) res_v_q <= 1'b0;
        end
    end

    // Two-entry output buffer, head entry drives the outputs
    logic [47:0] ent0_q, ent1_q;
    wire pop = v0_q & out_ready;
    wire [47:0] new_ent = {res_q[0], res_q[1]};
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            v0_q <= 1'b0;
            v1_q <= 1'b0;
            ent0_q <= '0;
            ent1_q <= '0;
        end else begin
            if (pop) begin
                ent0_q <= (push && !v1_q) ? new_ent : ent1_q;
                v0_q <= v1_q | push;
                ent1_q <= new_ent;
                v1_q <= push & v1_q;
            end else if (push) begin
                if (!v0_q) ent0_q <= new_ent;
                else ent1_q <= new_ent;
                v0_q <= 1'b1;
                v1_q <= v0_q;
            end
        end
    end
    assign out_valid = v0_q;
    assign out_i = ent0_q[47:24];
    assign out_q = ent0_q[23:0];
    assign in_ready = in_ready_q;

    // Checking helpers: phase length and pass length
    logic [7:0] run_len_q, pass_q;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            run_len_q <= '0;
            pass_q <= '0;
        end else begin
            run_len_q <= (in_a || st_q == S_PH_B) ? run_len_q + 8'h01 : 8'h00;
            // Cycles stalled by a full output buffer are not compute clocks
            if (release_ok) pass_q <= 8'h01;
            else if (st_q == S_WAIT) pass_q <= 8'h00;
            else if (!out_stall) pass_q <= pass_q + 8'h01;
        end
    end
    wire [7:0] want_len = 8'({1'b0, cur_taps} + 7'h01) >> 1;

    sequence s_release;
        st_q == S_WAIT && new_cnt_q >= `WAIT_COUNT;
    endsequence
    sequence s_enter_a;
        st_q == S_PH_A && k_q == 6'h00;
    endsequence

    chk_wait_release: assert property (@(posedge sys_clk) disable iff (rst)
        s_release |=> s_enter_a) else $error("wait did not release");
    chk_wait_hold: assert property (@(posedge sys_clk) disable iff (rst)
        st_q == S_WAIT && new_cnt_q < `WAIT_COUNT |=> st_q == S_WAIT)
        else $error("wait released early");
    chk_count_clear: assert property (@(posedge sys_clk) disable iff (rst)
        release_ok |=> new_cnt_q == 6'($past(new_cnt_q) + {5'h00, $past(cic_v_q)} - 6'h05))
        else $error("count not reduced by five");
    chk_read_offset: assert property (@(posedge sys_clk) disable iff (rst)
        s_enter_a |-> rd0 == ptr_t'(base_q - 6'h01 - (chain_mode ? 6'h02 : 6'h03)))
        else $error("phase A offset wrong");
    chk_phase_len: assert property (@(posedge sys_clk) disable iff (rst)
        (in_a || st_q == S_PH_B) && ph_last |-> run_len_q + 8'h01 == want_len)
        else $error("phase length wrong");
    chk_single_fir: assert property (@(posedge sys_clk) disable iff (rst)
        fwr_go && !chain_mode |=> st_q == S_FRUN && fin_run_q)
        else $error("final FIR not run inline");
    chk_loop_back: assert property (@(posedge sys_clk) disable iff (rst)
        st_q == S_LOOP |=> st_q == S_WAIT ##0 !second_q) else $error("no loop back");
    chk_cic_decim: assert property (@(posedge sys_clk) disable iff (rst)
        cic_v_q |-> $past(take) && $past(dec_cnt_q) == `CIC_LAST)
        else $error("CIC output off ratio");
    chk_pass_budget: assert property (@(posedge sys_clk) disable iff (rst)
        st_q == S_LOOP && !chain_mode && !v1_q |-> pass_q <= `BUDGET_CLKS)
        else $error("pass over budget");
    chk_fin_len: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(fin_run_q) && chain_mode |-> fin_run_q [*8] ##15 $fell(fin_run_q))
        else $error("final run length wrong");

endmodule // cic_polyphase_decimator

// *** inc/decim_consts.svh ***
// Purpose: Constants of the two-stage receive decimator.
// Assumes: One processing clock at 100 MHz.
// Notes: Tap counts and offsets per arrangement.
`ifndef DECIM_CONSTS_SVH
`define DECIM_CONSTS_SVH
`define CIC_STAGES 5
`define CIC_LAST 4'h9
`define CIC_SHIFT 17
`define WAIT_COUNT 6'h05
`define PEND_LIMIT 6'h10
`define SC_TAPS_A 6'h0C
`define SC_TAPS_B 6'h0D
`define SC_OFFS_A 6'h03
`define SC_TAPS_F 6'h1C
`define CC_TAPS_A 6'h22
`define CC_TAPS_B 6'h21
`define CC_OFFS_A 6'h02
`define CC_TAPS_F 6'h2C
`define PP_SHIFT 4
`define FIN_SHIFT 5
`define BUDGET_CLKS 8'h32
`endif

// *** inc/decim_pkg.sv ***
// Purpose: Types of the two-stage receive decimator.
// Assumes: Constants live in decim_consts.svh.
// Notes: State codes are one-hot.
package decim_pkg;
    typedef logic signed [23:0] sample_t;
    typedef logic signed [35:0] acc_t;
    typedef logic signed [39:0] cic_t;
    typedef logic [5:0] ptr_t;
    typedef enum logic [5:0] {
        S_WAIT = 6'h01,
        S_PH_A = 6'h02,
        S_PH_B = 6'h04,
        S_FWR = 6'h08,
        S_FRUN = 6'h10,
        S_LOOP = 6'h20
    } eng_state_e;
endpackage

// *** testbench/output_sink.sv ***
// Purpose: Far-side model taking 24-bit I/Q results off the output stream.
// Assumes: out_ready is driven 1 ns after each rising edge.
// Notes: In stall mode it accepts rarely, so the output buffer fills.
`timescale 1ns/100ps

module output_sink (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic stall_en,
    input wire logic out_valid,
    output logic out_ready
);
    integer seed = 17;

    initial begin
        out_ready = 1'b0;
    end

    // Always ready, or ready in about one cycle of sixty-four
    always @(posedge sys_clk) begin
        #1;
        if (rst) begin
            out_ready = 1'b0;
        end else begin
            out_ready = stall_en ? (($random(seed) & 63) == 0) : 1'b1;
        end
    end
endmodule // output_sink

// *** testbench/tb_cic_polyphase_fir_decimator.sv ***
// Purpose: Self-checking bench of the decimation chain with DC stimulus.
// Assumes: Unity taps; scaling >>>17, >>>4, >>>5 as the designer chose.
// Notes: Results compared once the filters have filled with samples.
`timescale 1ns/100ps

`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin err_count++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end

module tb_cic_polyphase_fir_decimator;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic chain_mode = 1'b0;
    logic in_valid = 1'b0;
    logic in_ready;
    logic signed [15:0] in_i = 16'h0000;
    logic signed [15:0] in_q = 16'h0000;
    logic out_valid;
    logic out_ready;
    logic [23:0] out_i;
    logic [23:0] out_q;
    logic stall_en = 1'b0;
    integer seed = 17;
    integer err_count = 0;
    integer comparisons = 0;
    integer cycles = 0;
    integer seen = 0;
    integer refused = 0;
    logic [23:0] exp_i[$];
    logic [23:0] exp_q[$];

    always #5 sys_clk = ~sys_clk;

    cic_polyphase_decimator dut_u (
        .sys_clk(sys_clk), .rst(rst), .chain_mode(chain_mode),
        .in_valid(in_valid), .in_ready(in_ready), .in_i(in_i), .in_q(in_q),
        .out_valid(out_valid), .out_ready(out_ready), .out_i(out_i), .out_q(out_q)
    );

    output_sink sink_u (
        .sys_clk(sys_clk), .rst(rst), .stall_en(stall_en),
        .out_valid(out_valid), .out_ready(out_ready)
    );

    // Steady DC result: CIC gain ten to the fifth, two phases, final FIR
    function automatic logic [23:0] dc_result(input int x, input logic chained);
        longint c;
        longint a;
        longint b;
        c = (longint'(x) * 100000) >>> 17;
        a = ((chained ? 34 : 12) * c) >>> 4;
        b = ((chained ? 33 : 13) * c) >>> 4;
        return 24'((((chained ? 22 : 14) * a) + ((chained ? 22 : 14) * b)) >>> 5);
    endfunction

    // Pop oldest note on each output transfer; skip the filling period
    always @(posedge sys_clk) begin
        if (!rst && out_valid === 1'b1 && out_ready === 1'b1) begin
            if (exp_i.size() == 0) begin
                `CHECK(out_valid, 1'b0)
            end else begin
                if (seen >= 70) begin
                    `CHECK(out_i, exp_i[0])
                    `CHECK(out_q, exp_q[0])
                end
                void'(exp_i.pop_front());
                void'(exp_q.pop_front());
                seen++;
            end
        end
    end

    // Cycle ceiling against a hang
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            err_count++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // One run: reset, stream 2500 DC samples, drain, check counts
    task automatic run_mode(input logic mode, input int xi, input int xq,
                            input logic stall, input logic gaps);
        int takes;
        int waited;
        logic held;
        takes = 0;
        seen = 0;
        refused = 0;
        #1 rst = 1'b1;
        chain_mode = mode;
        stall_en = stall;
        in_i = 16'(xi);
        in_q = 16'(xq);
        repeat (10) @(posedge sys_clk);
        #1 rst = 1'b0;
        in_valid = 1'b1;
        while (takes < 2500) begin
            @(posedge sys_clk);
            if (in_valid && in_ready === 1'b1) begin
                takes++;
                if (takes % 25 == 0) begin
                    exp_i.push_back(dc_result(xi, mode));
                    exp_q.push_back(dc_result(xq, mode));
                end
            end else if (in_valid && takes > 0) begin
                refused++;
            end
            // A refused sample stays offered until it is taken
            held = in_valid && in_ready !== 1'b1;
            #1 in_valid = (gaps && !held) ? (($random(seed) & 3) != 0) : 1'b1;
        end
        in_valid = 1'b0;
        waited = 0;
        while (exp_i.size() > 0 && waited < 6000) begin
            @(posedge sys_clk);
            waited++;
        end
        `CHECK(32'(exp_i.size()), 32'h0000_0000)
        `CHECK(32'(seen), 32'h0000_0064)
        if (stall) begin
            `CHECK(refused > 0, 1'b1)
        end else begin
            `CHECK(32'(refused), 32'h0000_0000)
        end
        $display("test mode %0d stall %0d done, outputs %0d", mode, stall, seen);
    endtask

    // Single fast, single stalled with gaps, chained fast
    initial begin
        run_mode(1'b0, 10000, -7000, 1'b0, 1'b0);
        run_mode(1'b0, -20000, 32767, 1'b1, 1'b1);
        run_mode(1'b1, 12345, -32768, 1'b0, 1'b0);
        tally_and_finish();
    end
endmodule // tb_cic_polyphase_fir_decimator
